// ---- common/nvm_pkg.sv ----
// constants for the nonvolatile memory protect, write and erase controller
// ****************************************************************
// Function
// - code protect low blocks programmer flash access; reads give zeros
// - processor fetches of flash ignore every protection setting
// - data protect low blocks programmer eeprom access; reads give zeros
// - processor eeprom reads and writes ignore the data protect bit
// - two-bit guard size sets the flash block shielded from self-modify
// - four user id words at 8000h-8003h readable and writable
// - device id 8006h and revision 8005h are read only
// - eeprom write stores one byte with implicit erase
// - eeprom write runs beside cpu; ends clearing go, setting done, irq
// - clearing go during an eeprom write has no effect
// - flash erase is whole rows only, never automatic on write
// - erase of a guarded address clears go, sets fault and erases nothing
// - row erase stalls the cpu, then sets done and irq
// - erase keeps write latches; operations keep the allow bit
// - region select one maps accesses to the auxiliary region
// - auxiliary read outside the map clears the data pair
// - user ids and eeprom read-write; id and config words read only
// - fault set on guarded go, one-cycle reset mid-operation, broken unlock
// - row erase clears all 32 words of the pointed row
// ****************************************************************
package nvm_pkg;
  // register offsets on the software port
  localparam logic [3:0]  OFS_CTRL    = 4'h0;
  localparam logic [3:0]  OFS_PTR     = 4'h1;
  localparam logic [3:0]  OFS_DATA    = 4'h2;
  localparam logic [3:0]  OFS_UNLOCK  = 4'h3;
  // control register bit positions
  localparam int          B_REGION    = 0;
  localparam int          B_ERASE     = 1;
  localparam int          B_ALLOW     = 2;
  localparam int          B_GO        = 3;
  localparam int          B_FAULT     = 4;
  localparam int          B_DONE      = 5;
  localparam int          B_IRQEN     = 6;
  localparam int          B_READ      = 7;
  localparam logic [7:0]  CTRL_RST    = 8'h00;
  // unlock keys, written in this order
  localparam logic [15:0] KEY_FIRST   = 16'h0055;
  localparam logic [15:0] KEY_SECOND  = 16'h00aa;
  // auxiliary region map
  localparam logic [15:0] ID_BASE     = 16'h8000;
  localparam logic [15:0] REV_ADDR    = 16'h8005;
  localparam logic [15:0] DEV_ADDR    = 16'h8006;
  localparam logic [15:0] CFG_LO      = 16'h8007;
  localparam logic [15:0] CFG_HI      = 16'h800a;
  localparam logic [15:0] EE_LO       = 16'hf000;
  localparam logic [15:0] EE_HI       = 16'hf0ff;
  localparam int          ROW_WORDS   = 32;
  localparam logic [13:0] ERASED_WORD = 14'h3fff;
  localparam logic [15:0] GUARD_SMALL = 16'h0200;
  // timing
  localparam int          CLK_NS      = 50;
  localparam int          EE_WRITE_NS = 4000000;
  localparam int          ERASE_NS    = 2000000;
endpackage

// ---- logic/nvm_ctrl.sv ----
// nonvolatile memory protect, write and erase controller
`timescale 1ns/1ns
`default_nettype none
module nvm_ctrl
  import nvm_pkg::*;
#(
  parameter int          FLASH_WORDS = 8192,
  parameter int          EE_CYC      = EE_WRITE_NS / CLK_NS,
  parameter int          ERASE_CYC   = ERASE_NS / CLK_NS,
  parameter logic [13:0] DEV_ID      = 14'h0123, // arbitrary value
  parameter logic [13:0] REV_ID      = 14'h0001  // arbitrary value
)(
  input  wire logic        MCLK,
  input  wire logic        RSTN,
  input  wire logic [3:0]  REG_ADDR,
  input  wire logic [15:0] REG_WDATA,
  input  wire logic        REG_WR,
  input  wire logic        REG_RD,
  output logic      [15:0] REG_RDATA,
  input  wire logic        CODE_PROTECT_N,
  input  wire logic        DATA_PROTECT_N,
  input  wire logic [1:0]  SELF_MODIFY_GUARD_SIZE,
  input  wire logic        EXT_RD,
  input  wire logic        EXT_WR,
  input  wire logic [15:0] EXT_ADDR,
  input  wire logic [13:0] EXT_WDATA,
  output logic      [13:0] EXT_RDATA,
  input  wire logic [15:0] FETCH_ADDR,
  output logic      [13:0] FETCH_DATA,
  output logic             CPU_STALL,
  output logic             NVM_IRQ
);
  localparam int AW = $clog2(FLASH_WORDS);

  // ****************************************************************
  // parameter checks
  // ****************************************************************
  if (FLASH_WORDS < 2 * ROW_WORDS || FLASH_WORDS > 32768
      || (1 << AW) != FLASH_WORDS)
  begin : g_bad_size
    $error("flash size must be a power of two, 64 to 32768");
  end
  if (EE_CYC < 1 || ERASE_CYC < 1 || EE_CYC > 131071
      || ERASE_CYC > 131071)
  begin : g_bad_time
    $error("operation cycle counts must be 1 to 131071");
  end

  // ****************************************************************
  // state and storage
  // ****************************************************************
  typedef enum logic [2:0]
  {
    ST_IDLE  = 3'b001,
    ST_WRITE = 3'b010,
    ST_ERASE = 3'b100
  } op_state_e;

  op_state_e   state_q;
  logic        region_q;
  logic        erase_q;
  logic        allow_q;
  logic        irqen_q;
  logic        fault_q;
  logic        done_q;
  logic        key1_q;
  logic        armed_q;
  logic [15:0] ptr_q;
  logic [13:0] data_q;
  logic [15:0] op_ptr_q;
  logic [13:0] op_data_q;
  logic        op_region_q;
  logic [16:0] cnt_q;
  logic [13:0] flash_q [FLASH_WORDS];
  logic [7:0]  ee_q    [256];
  logic [13:0] id_q    [4];

  // ****************************************************************
  // request decode
  // ****************************************************************
  logic        ctrl_wr;
  logic        nreg;
  logic        nerase;
  logic        nallow;
  logic        go_req;
  logic        in_ee;
  logic        in_id;
  logic        in_flash;
  logic        guard_hit;
  logic        target_bad;
  logic        start_ok;
  logic        refuse_hit;
  logic        unlock_break;
  logic        op_end;
  logic [15:0] guard_lim;
  logic [13:0] cfg_word;
  logic [13:0] rd_val;

  assign ctrl_wr = REG_WR && REG_ADDR == OFS_CTRL;
  assign nreg    = REG_WDATA[B_REGION];
  assign nerase  = REG_WDATA[B_ERASE];
  assign nallow  = REG_WDATA[B_ALLOW];
  assign go_req  = ctrl_wr && REG_WDATA[B_GO] && state_q == ST_IDLE;
  assign op_end  = state_q != ST_IDLE && cnt_q == 17'h0;

  // target classification for the region being written
  assign in_ee    = ptr_q >= EE_LO && ptr_q <= EE_HI;
  assign in_id    = ptr_q[15:2] == ID_BASE[15:2];
  assign in_flash = ptr_q < 16'(FLASH_WORDS);

  // shielded block starts at word zero
  always_comb
  begin
    unique case (SELF_MODIFY_GUARD_SIZE)
      2'b00: guard_lim = 16'(FLASH_WORDS);
      2'b01: guard_lim = 16'(FLASH_WORDS / 2);
      2'b10: guard_lim = GUARD_SMALL;
      2'b11: guard_lim = 16'h0000;
    endcase
  end
  assign guard_hit = !nreg && ptr_q < guard_lim;

  // auxiliary targets: ids erase or write, eeprom writes only
  always_comb
  begin
    if (nreg)
      target_bad = nerase ? !in_id : !(in_id || in_ee);
    else
      target_bad = !in_flash || guard_hit;
  end

  assign start_ok   = go_req && armed_q && nallow
                      && !target_bad;
  assign refuse_hit = go_req && armed_q && nallow
                      && target_bad;
  // any other write between the two keys breaks the sequence
  assign unlock_break = REG_WR && key1_q
                        && !(REG_ADDR == OFS_UNLOCK
                             && REG_WDATA == KEY_SECOND);

  // configuration word view
  assign cfg_word = {10'h000, SELF_MODIFY_GUARD_SIZE,
                     DATA_PROTECT_N, CODE_PROTECT_N};

  // processor read of the pointed location
  always_comb
  begin
    rd_val = 14'h0000;
    if (!nreg)
      rd_val = in_flash ? flash_q[ptr_q[AW-1:0]] : 14'h0000;
    else if (in_ee)
      rd_val = {6'h00, ee_q[ptr_q[7:0]]};
    else if (in_id)
      rd_val = id_q[ptr_q[1:0]];
    else if (ptr_q == REV_ADDR)
      rd_val = REV_ID;
    else if (ptr_q == DEV_ADDR)
      rd_val = DEV_ID;
    else if (ptr_q >= CFG_LO && ptr_q <= CFG_HI)
      rd_val = cfg_word;
  end

  // ****************************************************************
  // unlock sequence
  // ****************************************************************
  // first key, then second key as the very next write, arms one go
  always_ff @(posedge MCLK)
  begin
    if (!RSTN)
    begin
      key1_q  <= 1'b0;
      armed_q <= 1'b0;
    end
    else if (REG_WR)
    begin
      key1_q  <= REG_ADDR == OFS_UNLOCK && REG_WDATA == KEY_FIRST;
      armed_q <= key1_q && !unlock_break;
    end
  end

  // ****************************************************************
  // control register and operation sequencer
  // ****************************************************************
  // settings; allow bit only moves by software
  always_ff @(posedge MCLK)
  begin
    if (!RSTN)
    begin
      region_q <= CTRL_RST[B_REGION];
      erase_q  <= CTRL_RST[B_ERASE];
      allow_q  <= CTRL_RST[B_ALLOW];
      irqen_q  <= CTRL_RST[B_IRQEN];
    end
    else if (ctrl_wr)
    begin
      region_q <= nreg;
      erase_q  <= nerase;
      allow_q  <= nallow;
      irqen_q  <= REG_WDATA[B_IRQEN];
    end
  end

  // status flags; set wins over clear; long reset drops the run fault
  always_ff @(posedge MCLK)
  begin
    if (!RSTN)
    begin
      done_q  <= CTRL_RST[B_DONE];
      fault_q <= state_q != ST_IDLE;
    end
    else
    begin
      done_q  <= op_end || (ctrl_wr ? REG_WDATA[B_DONE]
                                    : done_q);
      fault_q <= refuse_hit || unlock_break
                 || (ctrl_wr ? REG_WDATA[B_FAULT] : fault_q);
    end
  end

  // go launches a timed operation; clearing go is not seen
  always_ff @(posedge MCLK)
  begin
    if (!RSTN)
    begin
      state_q     <= ST_IDLE;
      cnt_q       <= 17'h0;
      op_ptr_q    <= 16'h0;
      op_data_q   <= 14'h0;
      op_region_q <= 1'b0;
    end
    else
    begin
      unique case (state_q)
        ST_IDLE:
        begin
          if (start_ok)
          begin
            op_ptr_q    <= ptr_q;
            op_data_q   <= data_q;
            op_region_q <= nreg;
            if (nerase)
            begin
              state_q <= ST_ERASE;
              cnt_q   <= 17'(ERASE_CYC - 1);
            end
            else
            begin
              state_q <= ST_WRITE;
              cnt_q   <= 17'(EE_CYC - 1);
            end
          end
        end
        ST_WRITE, ST_ERASE:
        begin
          if (cnt_q == 17'h0)
            state_q <= ST_IDLE;
          else
            cnt_q <= cnt_q - 17'h1;
        end
      endcase
    end
  end

  // ****************************************************************
  // pointer and data pair
  // ****************************************************************
  always_ff @(posedge MCLK)
  begin
    if (!RSTN)
      ptr_q <= 16'h0;
    else if (REG_WR && REG_ADDR == OFS_PTR)
      ptr_q <= REG_WDATA;
  end

  // read request loads the pair, unmapped targets give zeros
  always_ff @(posedge MCLK)
  begin
    if (!RSTN)
      data_q <= 14'h0;
    else if (ctrl_wr && REG_WDATA[B_READ])
      data_q <= rd_val;
    else if (REG_WR && REG_ADDR == OFS_DATA)
      data_q <= REG_WDATA[13:0];
  end

  // ****************************************************************
  // memory arrays
  // ****************************************************************
  // commits on the last cycle; programmer writes gated by protect
  always_ff @(posedge MCLK)
  begin
    if (op_end && state_q == ST_WRITE && op_region_q)
    begin
      if (op_ptr_q[15:12] == EE_LO[15:12])
        ee_q[op_ptr_q[7:0]] <= op_data_q[7:0];
      else
        id_q[op_ptr_q[1:0]] <= op_data_q;
    end
    if (op_end && state_q == ST_ERASE && op_region_q)
      for (int i = 0; i < 4; i++)
        id_q[i] <= ERASED_WORD;
    if (EXT_WR && DATA_PROTECT_N && EXT_ADDR >= EE_LO
        && EXT_ADDR <= EE_HI)
      ee_q[EXT_ADDR[7:0]] <= EXT_WDATA[7:0];
  end

  // flash words: processor write only clears bits, programmer write replaces the word, erase is per row
  always_ff @(posedge MCLK)
  begin
    if (op_end && state_q == ST_WRITE && !op_region_q)
      flash_q[op_ptr_q[AW-1:0]] <= flash_q[op_ptr_q[AW-1:0]]
                                   & op_data_q;
    if (op_end && state_q == ST_ERASE && !op_region_q)
      for (int i = 0; i < ROW_WORDS; i++)
        flash_q[{op_ptr_q[AW-1:5], 5'(i)}] <= ERASED_WORD;
    if (EXT_WR && CODE_PROTECT_N && !EXT_ADDR[15]
        && EXT_ADDR < 16'(FLASH_WORDS))
      flash_q[EXT_ADDR[AW-1:0]] <= EXT_WDATA;
  end

  // ****************************************************************
  // outputs
  // ****************************************************************
  // register read port, one cycle after the strobe
  always_ff @(posedge MCLK)
  begin
    if (!RSTN)
      REG_RDATA <= 16'h0;
    else if (REG_RD)
    begin
      unique case (REG_ADDR)
        OFS_CTRL:
          REG_RDATA <= {8'h00, 1'b0, irqen_q, done_q, fault_q,
                        state_q != ST_IDLE, allow_q, erase_q,
                        region_q};
        OFS_PTR:  REG_RDATA <= ptr_q;
        OFS_DATA: REG_RDATA <= {2'b00, data_q};
        default:  REG_RDATA <= 16'h0;
      endcase
    end
    else
      REG_RDATA <= 16'h0;
  end

  // programmer reads return zeros when protected
  always_ff @(posedge MCLK)
  begin
    if (!RSTN)
      EXT_RDATA <= 14'h0;
    else if (!EXT_RD)
      EXT_RDATA <= 14'h0;
    else if (EXT_ADDR >= EE_LO && EXT_ADDR <= EE_HI)
      EXT_RDATA <= DATA_PROTECT_N ? {6'h00, ee_q[EXT_ADDR[7:0]]}
                                  : 14'h0;
    else if (!EXT_ADDR[15] && EXT_ADDR < 16'(FLASH_WORDS))
      EXT_RDATA <= CODE_PROTECT_N ? flash_q[EXT_ADDR[AW-1:0]]
                                  : 14'h0;
    else
      EXT_RDATA <= 14'h0;
  end

  // processor fetch path never gated
  always_ff @(posedge MCLK)
  begin
    if (!RSTN)
      FETCH_DATA <= 14'h0;
    else
      FETCH_DATA <= flash_q[FETCH_ADDR[AW-1:0]];
  end

  // stall only while an erase runs, row or user id; interrupt from flags
  always_ff @(posedge MCLK)
  begin
    if (!RSTN)
    begin
      CPU_STALL <= 1'b0;
      NVM_IRQ   <= 1'b0;
    end
    else
    begin
      CPU_STALL <= (state_q == ST_IDLE && start_ok && nerase)
                   || (state_q == ST_ERASE && cnt_q != 17'h0);
      NVM_IRQ   <= (op_end || (ctrl_wr ? REG_WDATA[B_DONE] : done_q))
                   && (ctrl_wr ? REG_WDATA[B_IRQEN] : irqen_q);
    end
  end

  // ****************************************************************
  // assertions
  // ****************************************************************
  default clocking cb @(posedge MCLK); endclocking
  default disable iff (!RSTN);

  a_ext_flash_zero: assert property (EXT_RD && !EXT_ADDR[15]
    && !CODE_PROTECT_N |=> EXT_RDATA == 14'h0)
    else $error("protected flash read not zero");
  a_ext_ee_zero: assert property (EXT_RD && EXT_ADDR >= EE_LO
    && !DATA_PROTECT_N |=> EXT_RDATA == 14'h0)
    else $error("protected eeprom read not zero");
  a_fetch_open: assert property (RSTN |=> FETCH_DATA
    === $past(flash_q[FETCH_ADDR[AW-1:0]]))
    else $error("fetch data wrong");
  a_guard_refuse: assert property (refuse_hit
    |=> state_q == ST_IDLE && fault_q)
    else $error("guarded go not refused");
  a_locked_go: assert property (go_req && !armed_q
    |=> state_q == ST_IDLE)
    else $error("go accepted without unlock");
  a_write_runs: assert property (state_q == ST_WRITE
    && cnt_q != 17'h0 |=> state_q == ST_WRITE)
    else $error("write ended early");
  a_done_end: assert property (op_end
    |=> state_q == ST_IDLE && done_q && NVM_IRQ == irqen_q)
    else $error("done not signalled");
  a_erase_stall: assert property (start_ok && nerase
    |=> CPU_STALL [*2])
    else $error("erase without stall");
  a_allow_kept: assert property (state_q != ST_IDLE && !ctrl_wr
    |=> $stable(allow_q))
    else $error("allow bit changed");
  a_oob_zero: assert property (ctrl_wr && REG_WDATA[B_READ]
    && nreg && ptr_q == 16'h8004 |=> data_q == 14'h0)
    else $error("unmapped read not zero");

  c_ee_write: cover property (state_q == ST_WRITE && op_end);
  c_erase:    cover property (state_q == ST_ERASE && op_end);
  c_refused:  cover property (refuse_hit);
  c_broken:   cover property (unlock_break);
endmodule
`default_nettype wire

// ---- test/nvm_host_model.sv ----
// software and programmer model driving the nvm controller
`timescale 1ns/1ns
`default_nettype none
module nvm_host_model
  import nvm_pkg::*;
(
  input  wire logic        clk,
  input  wire logic [15:0] rdata,
  input  wire logic [13:0] ext_rdata,
  output logic      [3:0]  addr,
  output logic      [15:0] wdata,
  output logic             wr,
  output logic             rd,
  output logic      [15:0] ext_addr,
  output logic      [13:0] ext_wdata,
  output logic             ext_wr,
  output logic             ext_rd
);
  // idle bus at time zero
  initial
  begin
    addr      = 4'h0;
    wdata     = 16'h0000;
    wr        = 1'b0;
    rd        = 1'b0;
    ext_addr  = 16'h0000;
    ext_wdata = 14'h0000;
    ext_wr    = 1'b0;
    ext_rd    = 1'b0;
  end

  // one-cycle write strobe, then one idle cycle
  task automatic reg_wr(input logic [3:0] a, input logic [15:0] d);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
    @(posedge clk);
  endtask

  // read strobe; data taken in the cycle after
  task automatic reg_rd(input logic [3:0] a, output logic [15:0] d);
    addr <= a;
    rd   <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 d = rdata;
    @(posedge clk);
  endtask

  // programmer read or write, answer one cycle later
  task automatic ext_access(input logic w, input logic [15:0] a,
                            input logic [13:0] d, output logic [13:0] q);
    ext_addr  <= a;
    ext_wdata <= d;
    ext_wr    <= w;
    ext_rd    <= !w;
    @(posedge clk);
    ext_wr <= 1'b0;
    ext_rd <= 1'b0;
    #1 q = ext_rdata;
    @(posedge clk);
  endtask

  // pointer, unbroken key pair, then the go write
  task automatic launch(input logic [15:0] c, input logic [15:0] p);
    reg_wr(OFS_PTR, p);
    reg_wr(OFS_UNLOCK, KEY_FIRST);
    reg_wr(OFS_UNLOCK, KEY_SECOND);
    reg_wr(OFS_CTRL, c);
  endtask
endmodule
`default_nettype wire

// ---- test/nvm_ctrl_test.sv ----
// self-checking bench for the nvm controller
`timescale 1ns/1ns
`default_nettype none
module nvm_ctrl_test
  import nvm_pkg::*;
;
  localparam logic [13:0] DEV_VAL = 14'h0abc; // arbitrary value
  localparam logic [13:0] REV_VAL = 14'h0002; // arbitrary value
  logic        mclk = 1'b0;
  logic        rstn = 1'b0;
  logic        code_protect_n = 1'b1;
  logic        data_protect_n = 1'b1;
  logic [1:0]  self_modify_guard_size = 2'b11;
  logic [15:0] fetch_addr = 16'h0000;
  logic [3:0]  reg_addr;
  logic [15:0] reg_wdata;
  logic        reg_wr;
  logic        reg_rd;
  logic [15:0] reg_rdata;
  logic        ext_rd;
  logic        ext_wr;
  logic [15:0] ext_addr;
  logic [13:0] ext_wdata;
  logic [13:0] ext_rdata;
  logic [13:0] fetch_data;
  logic        cpu_stall;
  logic        nvm_irq;
  int          failures = 0;
  int          check_count = 0;

  // 50 ns clock
  always #25 mclk = ~mclk;

  nvm_ctrl #(
    .FLASH_WORDS (64),
    .EE_CYC      (12),
    .ERASE_CYC   (6),
    .DEV_ID      (DEV_VAL),
    .REV_ID      (REV_VAL)
  ) nvm_ctrl_i (
    .MCLK                   (mclk),
    .RSTN                   (rstn),
    .REG_ADDR               (reg_addr),
    .REG_WDATA              (reg_wdata),
    .REG_WR                 (reg_wr),
    .REG_RD                 (reg_rd),
    .REG_RDATA              (reg_rdata),
    .CODE_PROTECT_N         (code_protect_n),
    .DATA_PROTECT_N         (data_protect_n),
    .SELF_MODIFY_GUARD_SIZE (self_modify_guard_size),
    .EXT_RD                 (ext_rd),
    .EXT_WR                 (ext_wr),
    .EXT_ADDR               (ext_addr),
    .EXT_WDATA              (ext_wdata),
    .EXT_RDATA              (ext_rdata),
    .FETCH_ADDR             (fetch_addr),
    .FETCH_DATA             (fetch_data),
    .CPU_STALL              (cpu_stall),
    .NVM_IRQ                (nvm_irq)
  );

  nvm_host_model nvm_host_model_i (
    .clk       (mclk),
    .rdata     (reg_rdata),
    .ext_rdata (ext_rdata),
    .addr      (reg_addr),
    .wdata     (reg_wdata),
    .wr        (reg_wr),
    .rd        (reg_rd),
    .ext_addr  (ext_addr),
    .ext_wdata (ext_wdata),
    .ext_wr    (ext_wr),
    .ext_rd    (ext_rd)
  );

  // ****************************************************************
  // helpers
  // ****************************************************************
  task automatic complete_run();
    $display("checks %0d mismatches %0d", check_count, failures);
    if (failures == 0 && check_count > 0)
    begin
      $display("Test passed");
    end
    else
    begin
      $display("Test failed");
    end
    $finish;
  endtask

  task automatic check(input string what, input logic [15:0] seen,
                       input logic [15:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      failures++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // poll the busy bit under a bound
  task automatic wait_idle();
    logic [15:0] v;
    for (int n = 0; n < 40; n++)
    begin
      nvm_host_model_i.reg_rd(OFS_CTRL, v);
      if (v[B_GO] === 1'b0)
        return;
    end
    failures++;
    complete_run();
  endtask

  // wait for the stall level under a bound
  task automatic wait_stall(input logic lvl);
    for (int n = 0; n < 20; n++)
    begin
      #1;
      if (cpu_stall === lvl)
        return;
      @(posedge mclk);
    end
    failures++;
    complete_run();
  endtask

  task automatic fetch(input logic [15:0] a, output logic [13:0] q);
    fetch_addr <= a;
    @(posedge mclk);
    #1 q = fetch_data;
    @(posedge mclk);
  endtask

  // auxiliary read through the data pair
  task automatic aux_rd(input logic [15:0] a, output logic [15:0] q);
    nvm_host_model_i.reg_wr(OFS_PTR, a);
    nvm_host_model_i.reg_wr(OFS_CTRL, 16'h0081);
    nvm_host_model_i.reg_rd(OFS_DATA, q);
  endtask

  task automatic erase_row(input logic [15:0] p);
    logic [15:0] v;
    nvm_host_model_i.reg_wr(OFS_CTRL, 16'h0000);
    nvm_host_model_i.launch(16'h000e, p);
    wait_stall(1'b1);
    wait_stall(1'b0);
    nvm_host_model_i.reg_rd(OFS_CTRL, v);
    check("erase end", v & 16'h003c, 16'h0024);
    check("irq off", {15'h0000, nvm_irq}, 16'h0000);
  endtask

  // ****************************************************************
  // scenarios
  // ****************************************************************
  task automatic t_eeprom();
    logic [15:0] v;
    logic [13:0] q;
    nvm_host_model_i.reg_wr(OFS_DATA, 16'h005a);
    nvm_host_model_i.launch(16'h004d, 16'hf005);
    nvm_host_model_i.reg_wr(OFS_CTRL, 16'h0045);
    nvm_host_model_i.reg_rd(OFS_CTRL, v);
    check("go held", v & 16'h0008, 16'h0008);
    wait_idle();
    nvm_host_model_i.reg_rd(OFS_CTRL, v);
    check("ee end", v & 16'h007c, 16'h0064);
    check("irq", {15'h0000, nvm_irq}, 16'h0001);
    nvm_host_model_i.ext_access(1'b0, 16'hf005, 14'h0000, q);
    check("ext ee", {2'b00, q}, 16'h005a);
    data_protect_n <= 1'b0;
    nvm_host_model_i.ext_access(1'b1, 16'hf005, 14'h0011, q);
    nvm_host_model_i.ext_access(1'b0, 16'hf005, 14'h0000, q);
    check("ext ee hidden", {2'b00, q}, 16'h0000);
    aux_rd(16'hf005, v);
    check("cpu ee", v, 16'h005a);
  endtask

  task automatic t_erase();
    logic [15:0] v;
    logic [13:0] q;
    logic        bad;
    erase_row(16'h0000);
    nvm_host_model_i.ext_access(1'b1, 16'h0001, 14'h1234, q);
    for (int g = 3; g >= 0; g--)
    begin
      self_modify_guard_size <= 2'(g);
      bad = (g == 0) || (g == 2);
      nvm_host_model_i.ext_access(1'b1, 16'h0021, 14'h1234, q);
      if (bad)
      begin
        nvm_host_model_i.reg_wr(OFS_CTRL, 16'h0000);
        nvm_host_model_i.launch(16'h000e, 16'h0020);
        nvm_host_model_i.reg_rd(OFS_CTRL, v);
        check("guarded", v & 16'h0038, 16'h0010);
      end
      else
        erase_row(16'h0020);
      fetch(16'h0021, q);
      check("row word", {2'b00, q}, bad ? 16'h1234 : 16'h3fff);
    end
    fetch(16'h003f, q);
    check("row end", {2'b00, q}, 16'h3fff);
    fetch(16'h0001, q);
    check("row kept", {2'b00, q}, 16'h1234);
    code_protect_n <= 1'b0;
    nvm_host_model_i.ext_access(1'b0, 16'h0001, 14'h0000, q);
    check("ext fl hidden", {2'b00, q}, 16'h0000);
    nvm_host_model_i.ext_access(1'b1, 16'h0001, 14'h0000, q);
    fetch(16'h0001, q);
    check("cpu fetch", {2'b00, q}, 16'h1234);
  endtask

  task automatic t_ids();
    logic [15:0] v;
    aux_rd(DEV_ADDR, v);
    check("dev id", v, {2'b00, DEV_VAL});
    aux_rd(REV_ADDR, v);
    check("rev id", v, {2'b00, REV_VAL});
    aux_rd(16'h8004, v);
    check("hole", v, 16'h0000);
    nvm_host_model_i.reg_wr(OFS_CTRL, 16'h0000);
    nvm_host_model_i.launch(16'h000f, ID_BASE);
    wait_idle();
    nvm_host_model_i.reg_wr(OFS_DATA, 16'h2abc);
    nvm_host_model_i.launch(16'h000d, ID_BASE + 16'h0001);
    wait_idle();
    aux_rd(ID_BASE + 16'h0001, v);
    check("user id", v, 16'h2abc);
    nvm_host_model_i.launch(16'h000d, DEV_ADDR);
    nvm_host_model_i.reg_rd(OFS_CTRL, v);
    check("id write", v & 16'h0018, 16'h0010);
    aux_rd(DEV_ADDR, v);
    check("dev kept", v, {2'b00, DEV_VAL});
    nvm_host_model_i.reg_rd(4'h9, v);
    check("unmapped", v, 16'h0000);
  endtask

  task automatic t_unlock();
    logic [15:0] v;
    nvm_host_model_i.reg_wr(OFS_CTRL, 16'h0000);
    nvm_host_model_i.reg_wr(OFS_UNLOCK, KEY_FIRST);
    nvm_host_model_i.reg_wr(OFS_PTR, 16'hf010);
    nvm_host_model_i.reg_rd(OFS_CTRL, v);
    check("broken key", v & 16'h0010, 16'h0010);
    nvm_host_model_i.reg_wr(OFS_CTRL, 16'h000d);
    nvm_host_model_i.reg_rd(OFS_CTRL, v);
    check("go refused", v & 16'h0018, 16'h0000);
  endtask

  task automatic t_reset();
    logic [15:0] v;
    nvm_host_model_i.reg_wr(OFS_CTRL, 16'h0000);
    nvm_host_model_i.launch(16'h000d, 16'hf020);
    // one reset edge; a longer hold clears the run fault again
    rstn <= 1'b0;
    @(posedge mclk);
    rstn <= 1'b1;
    #1 check("reset rdata", reg_rdata, 16'h0000);
    @(posedge mclk);
    nvm_host_model_i.reg_rd(OFS_CTRL, v);
    check("reset fault", v & 16'h0018, 16'h0010);
  endtask

  // reset, scenarios, verdict
  initial
  begin
    repeat (10) @(posedge mclk);
    rstn <= 1'b1;
    @(posedge mclk);
    t_eeprom();
    t_erase();
    t_ids();
    t_unlock();
    t_reset();
    complete_run();
  end
endmodule
`default_nettype wire
